//--- verif/pmfc_chk.sv
module pmfc_chk (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Watched inputs
  input wire logic i_perf_request_pin,
  input wire logic i_low_power_request_pin,
  input wire logic i_perf_pin_unmask,
  input wire logic i_first_buck_hyst_enable,
  input wire logic i_mask_tsd,
  input wire logic i_mask_twarn,
  input wire logic i_tsd_hot,
  input wire logic i_twarn,
  input wire logic i_headroom_low,
  input wire logic [3:0] i_high_side_overcurrent,
  input wire logic [3:0] i_fb_below_fold,
  input wire logic [3:0] i_neg_limit,
  input wire logic [3:0] i_forced_pwm,
  input wire logic [1:0] i_ldo_limit,
  // Watched outputs
  input wire logic [5:0] o_channel_enable,
  input wire logic [3:0] o_end_on_time,
  input wire logic [3:0] o_low_side_off,
  input wire logic [3:0] o_foldback,
  input wire logic o_hysteretic_light_load,
  input wire logic o_reset_out_n,
  input wire logic o_irq_out_n,
  input wire logic [1:0] o_mode,
  input wire logic [3:0] o_oc_status,
  input wire logic [1:0] o_ldo_limit_status
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  a_on_time_end: assert property (o_end_on_time == i_high_side_overcurrent)
    else $error("on-time not cut by overcurrent");
  a_hyst_gate: assert property (o_hysteretic_light_load ==
    (i_first_buck_hyst_enable && i_headroom_low)) else $error("hysteretic gate wrong");
  a_tsd_stop: assert property (i_tsd_hot |=> !o_reset_out_n && o_channel_enable == 6'h00)
    else $error("shutdown left channels on");
  a_tsd_irq: assert property (i_tsd_hot && !i_mask_tsd |=> !o_irq_out_n)
    else $error("shutdown interrupt missing");
  a_warn_irq: assert property (i_twarn && !i_mask_twarn |=> !o_irq_out_n)
    else $error("warning interrupt missing");
  // Four samples cover the two-flop pin synchroniser
  a_perf_masked: assert property ((!i_perf_pin_unmask)[*4] ##0
    o_mode != pmfc_pkg::PMFC_PERF |=> o_mode != pmfc_pkg::PMFC_PERF)
    else $error("masked performance pin took effect");
  a_lowpwr_holds: assert property (i_low_power_request_pin[*4] ##0
    (o_mode == pmfc_pkg::PMFC_LOWPWR && o_reset_out_n && !i_tsd_hot)
    |=> o_mode == pmfc_pkg::PMFC_LOWPWR) else $error("low-power left early");
  a_perf_holds: assert property ((i_perf_request_pin && i_perf_pin_unmask)[*4] ##0
    (o_mode == pmfc_pkg::PMFC_PERF && o_reset_out_n && !i_tsd_hot)
    |=> o_mode == pmfc_pkg::PMFC_PERF) else $error("performance left early");
  a_fold_entry: assert property (i_high_side_overcurrent[1] && i_fb_below_fold[1]
    |=> o_foldback[1]) else $error("foldback not entered");
  a_neg_lowside: assert property ((~o_low_side_off & i_neg_limit & i_forced_pwm) == 4'h0)
    else $error("low side kept on at negative limit");
  a_ldo_report: assert property (i_ldo_limit[1] |=> o_ldo_limit_status[1])
    else $error("ldo limit not reported");
  a_oc_sticky: assert property (($past(o_oc_status) & ~o_oc_status) == 4'h0)
    else $error("overcurrent status lost");
endmodule : pmfc_chk

bind pmfc_top pmfc_chk i_pmfc_chk (.i_mclk, .i_reset_n, .i_perf_request_pin,
  .i_low_power_request_pin, .i_perf_pin_unmask, .i_first_buck_hyst_enable, .i_mask_tsd,
  .i_mask_twarn, .i_tsd_hot, .i_twarn, .i_headroom_low, .i_high_side_overcurrent,
  .i_fb_below_fold, .i_neg_limit, .i_forced_pwm, .i_ldo_limit, .o_channel_enable,
  .o_end_on_time, .o_low_side_off, .o_foldback, .o_hysteretic_light_load, .o_reset_out_n,
  .o_irq_out_n, .o_mode, .o_oc_status, .o_ldo_limit_status);

//--- verif/pmfc_host.sv
module pmfc_host (
  // Clock
  input wire logic i_mclk,
  // Pins toward the device
  output logic o_perf_request_pin,
  output logic o_low_power_request_pin,
  output logic o_power_hold_pin,
  output logic o_start_button_n,
  output logic o_perf_pin_unmask
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_perf_request_pin = 1'b0;
    o_low_power_request_pin = 1'b0;
    o_power_hold_pin = 1'b0;
    o_start_button_n = 1'b1;
    o_perf_pin_unmask = 1'b0;
  end
  // Levels move off the sampling edge; callers may raise low power while perf is still high
  task automatic set_pins(input logic perf, input logic lp, input logic hold, input logic unm);
    @(negedge i_mclk);
    o_perf_request_pin = perf;
    o_low_power_request_pin = lp;
    o_power_hold_pin = hold;
    o_perf_pin_unmask = unm;
  endtask : set_pins
  task automatic press_start();
    @(negedge i_mclk);
    o_start_button_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    o_start_button_n = 1'b1;
  endtask : press_start
endmodule : pmfc_host

//--- verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 50;
  localparam logic [47:0] ACT = 48'h20_24_30_28_40_50;
  localparam logic [47:0] PRF = 48'h10_10_44_10_10_10;
  localparam logic [47:0] LOW = 48'h1c_1e_2c_22_3c_4c;
  localparam logic [47:0] PRF_EXP = 48'h20_24_44_28_40_50;
  int err_total = 0;
  int check_count = 0;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  wire i_perf_request_pin, i_low_power_request_pin, i_power_hold_pin;
  wire i_start_button_n, i_perf_pin_unmask;
  logic i_first_buck_hyst_enable = 1'b0;
  logic [3:0] i_per_channel_hiccup_select = 4'h0;
  logic [3:0] i_in_sequence = 4'hd;
  logic i_mask_tsd = 1'b1;
  logic i_mask_twarn = 1'b0;
  logic i_mask_hiccup = 1'b1;
  logic [47:0] i_active_vcode = ACT;
  logic [47:0] i_perf_vcode = PRF;
  logic [5:0] i_perf_programmed = 6'h08;
  logic [47:0] i_lowpwr_vcode = LOW;
  logic i_tsd_hot = 1'b0;
  logic i_tsd_cool = 1'b1;
  logic i_twarn = 1'b0;
  logic i_headroom_low = 1'b0;
  logic [5:0] i_power_good_raw = 6'h3f;
  logic [3:0] i_hs_turn_on = 4'h0;
  logic [3:0] i_high_side_overcurrent = 4'h0;
  logic [3:0] i_fb_below_fold = 4'h0;
  logic [3:0] i_neg_limit = 4'h0;
  logic [3:0] i_forced_pwm = 4'h0;
  logic [1:0] i_ldo_limit = 2'h0;
  logic [5:0] o_channel_enable, o_soft_start, o_power_good;
  logic [47:0] o_target_vcode;
  logic [3:0] o_end_on_time, o_low_side_off, o_foldback, o_oc_status, o_neg_limit_status;
  logic o_hysteretic_light_load, o_reset_out_n, o_irq_out_n, o_tsd_status, o_twarn_status;
  logic [1:0] o_mode, o_ldo_limit_status;
  // Short counts keep the run small
  pmfc_top #(.RESTART_CYCLES(RC), .SS_CYCLES(10), .RST_DELAY_CYCLES(4)) i_pmfc_top (.*);
  pmfc_host i_pmfc_host (.i_mclk, .o_perf_request_pin(i_perf_request_pin),
    .o_low_power_request_pin(i_low_power_request_pin), .o_power_hold_pin(i_power_hold_pin),
    .o_start_button_n(i_start_button_n), .o_perf_pin_unmask(i_perf_pin_unmask));
  always #12.5 i_mclk = ~i_mclk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : tick
  function automatic logic [47:0] obs(input int sel);
    case (sel)
      0: return {47'h0, o_reset_out_n};
      1: return {46'h0, o_mode};
      default: return o_target_vcode;
    endcase
  endfunction : obs
  // Bounded wait; a lapse shows up as a failed compare
  task automatic wait_for(input int sel, input logic [47:0] exp);
    int n;
    n = 0;
    while (obs(sel) !== exp && n < 2000) begin
      @(negedge i_mclk);
      n++;
    end
    chk(obs(sel), exp);
    if (n == 2000)
      final_report();
  endtask : wait_for
  task automatic pulse(input int b, input int n, input logic oc);
    repeat (n) begin
      @(negedge i_mclk);
      i_hs_turn_on[b] = 1'b1;
      i_high_side_overcurrent[b] = oc;
      #1 chk(o_end_on_time, {3'h0, oc} << b);
      @(negedge i_mclk);
      i_hs_turn_on[b] = 1'b0;
      i_high_side_overcurrent[b] = 1'b0;
    end
  endtask : pulse
  task automatic t_start();
    chk({o_channel_enable, o_mode, o_irq_out_n}, 9'h001);
    i_pmfc_host.press_start();
    wait_for(0, 1);
    chk({o_channel_enable, o_power_good}, 12'hffd);
    wait_for(2, ACT);
    i_first_buck_hyst_enable = 1'b1;
    #1 chk(o_hysteretic_light_load, 0);
    i_headroom_low = 1'b1;
    #1 chk(o_hysteretic_light_load, 1);
    $display("start done");
  endtask : t_start
  task automatic t_modes();
    i_pmfc_host.set_pins(1, 0, 1, 0);
    tick(10);
    chk(o_mode, pmfc_pkg::PMFC_ACTIVE);
    i_pmfc_host.set_pins(1, 0, 1, 1);
    wait_for(1, pmfc_pkg::PMFC_PERF);
    wait_for(2, PRF_EXP);
    i_pmfc_host.set_pins(1, 1, 1, 1);
    tick(10);
    chk(o_mode, pmfc_pkg::PMFC_PERF);
    i_pmfc_host.set_pins(0, 1, 1, 1);
    wait_for(1, pmfc_pkg::PMFC_LOWPWR);
    wait_for(2, LOW);
    i_pmfc_host.set_pins(1, 1, 1, 1);
    tick(10);
    chk(o_mode, pmfc_pkg::PMFC_LOWPWR);
    i_pmfc_host.set_pins(1, 0, 1, 1);
    wait_for(1, pmfc_pkg::PMFC_PERF);
    $display("modes done");
  endtask : t_modes
  task automatic t_tsd();
    i_tsd_hot = 1'b1;
    i_tsd_cool = 1'b0;
    tick(2);
    chk({o_channel_enable, o_reset_out_n, o_irq_out_n, o_tsd_status}, 9'h002);
    i_tsd_hot = 1'b0;
    tick(20);
    chk(o_channel_enable, 6'h00);
    i_tsd_cool = 1'b1;
    tick(RC - 5);
    chk(o_channel_enable, 6'h00);
    wait_for(0, 1);
    chk(o_mode, pmfc_pkg::PMFC_PERF);
    wait_for(2, PRF_EXP);
    $display("thermal shutdown done");
  endtask : t_tsd
  task automatic t_twarn();
    chk(o_irq_out_n, 1);
    i_twarn = 1'b1;
    tick(2);
    i_twarn = 1'b0;
    chk({o_irq_out_n, o_reset_out_n, o_channel_enable, o_twarn_status}, 9'h0ff);
    i_pmfc_host.set_pins(0, 0, 1, 1);
    $display("warning done");
  endtask : t_twarn
  task automatic t_oc_global();
    i_per_channel_hiccup_select = 4'h2;
    i_power_good_raw = 6'h3e;
    pulse(0, 14, 1);
    tick(3);
    chk(o_channel_enable, 6'h3f);
    pulse(0, 1, 1);
    tick(3);
    chk({o_channel_enable, o_reset_out_n, o_oc_status[0]}, 8'h01);
    i_power_good_raw = 6'h3f;
    tick(RC - 10);
    chk(o_channel_enable, 6'h00);
    wait_for(0, 1);
    $display("global hiccup done");
  endtask : t_oc_global
  task automatic t_oc_chan();
    int n;
    i_power_good_raw = 6'h3d;
    i_fb_below_fold[1] = 1'b1;
    pulse(1, 14, 1);
    chk(o_foldback[1], 1);
    i_fb_below_fold[1] = 1'b0;
    pulse(1, 15, 0);
    tick(2);
    chk(o_foldback[1], 0);
    pulse(1, 14, 1);
    tick(3);
    chk(o_channel_enable, 6'h3f);
    pulse(1, 1, 1);
    n = 0;
    while (o_channel_enable[1] !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    chk({o_channel_enable, o_reset_out_n}, 7'h7b);
    if (n == 10) final_report();
    n = 0;
    while (o_soft_start[1] !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(n >= 29 && n <= 31, 1);
    if (n == 100) final_report();
    i_power_good_raw = 6'h3f;
    $display("channel hiccup done");
  endtask : t_oc_chan
  task automatic t_limits();
    i_forced_pwm = 4'h4;
    i_neg_limit = 4'h4;
    #1 chk(o_low_side_off[2], 1);
    tick(1);
    i_neg_limit = 4'h0;
    i_ldo_limit = 2'h3;
    tick(3);
    chk({o_reset_out_n, o_neg_limit_status[2], o_ldo_limit_status}, 4'hf);
    i_ldo_limit = 2'h0;
    i_mask_twarn = 1'b1;
    i_mask_tsd = 1'b0;
    i_tsd_hot = 1'b1;
    tick(2);
    chk({o_irq_out_n, o_tsd_status}, 2'h1);
    $display("limits done");
  endtask : t_limits
  initial begin
    tick(10);
    i_reset_n = 1'b1;
    tick(3);
    t_start();
    t_modes();
    t_tsd();
    t_twarn();
    t_oc_global();
    t_oc_chan();
    t_limits();
    final_report();
  end
endmodule : testbench

//--- verilog/pmfc_buck_oc.sv
module pmfc_buck_oc (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Switching events
  input wire logic i_hs_turn_on,
  input wire logic i_high_side_overcurrent,
  input wire logic i_fb_below_fold,
  input wire logic i_power_good,
  input wire logic i_neg_limit,
  input wire logic i_forced_pwm,
  // Hiccup control
  input wire logic i_hiccup_clear,
  // Outputs
  output logic o_end_on_time,
  output logic o_low_side_off,
  output logic o_hiccup,
  output logic o_foldback,
  output logic o_oc_status,
  output logic [3:0] o_oc_count
);
  typedef struct packed {
    logic [3:0] oc_cnt;
    logic [3:0] clean_cnt;
    logic fold;
    logic hiccup;
    logic oc_seen;
  } pmfc_buck_oc_t;
  pmfc_buck_oc_t state;
  pmfc_buck_oc_t next_state;

  always_comb begin
    next_state = state;
    if (i_hiccup_clear) begin
      next_state.hiccup = 1'b0;
      next_state.oc_cnt = 4'h0;
      next_state.clean_cnt = 4'h0;
    end
    // Counts only switching events, so foldback rate does not matter
    if (i_high_side_overcurrent) begin // RL19
      next_state.oc_seen = 1'b1;
      next_state.clean_cnt = 4'h0;
      if (state.oc_cnt != pmfc_pkg::OC_EOC) begin
        next_state.oc_cnt = state.oc_cnt + 4'h1; // RL12
      end
      if (i_fb_below_fold) begin
        next_state.fold = 1'b1; // RL11
      end
    end else if (i_hs_turn_on) begin
      if (state.clean_cnt == pmfc_pkg::CLEAN_PULSES - 4'h1) begin
        next_state.oc_cnt = 4'h0; // RL18
        next_state.clean_cnt = 4'h0;
        next_state.fold = 1'b0;
      end else begin
        next_state.clean_cnt = state.clean_cnt + 4'h1; // RL18
      end
    end
    // Stale full count must not re-arm
    if (state.oc_cnt == pmfc_pkg::OC_EOC && !i_power_good && !state.hiccup) begin
      next_state.hiccup = 1'b1; // RL13
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_end_on_time = i_high_side_overcurrent; // RL12
  assign o_low_side_off = (i_neg_limit && i_forced_pwm) || state.hiccup; // RL21
  assign o_hiccup = state.hiccup; // RL13
  assign o_foldback = state.fold; // RL11
  assign o_oc_status = state.oc_seen; // RL20
  assign o_oc_count = state.oc_cnt;
endmodule : pmfc_buck_oc

//--- verilog/pmfc_pkg.sv
package pmfc_pkg;
  // Channel counts
  localparam int NUM_BUCK = 4;
  localparam int NUM_LDO = 2;
  localparam int NUM_CH = NUM_BUCK + NUM_LDO;
  // Clock rate and restart delay
  localparam int CLK_HZ = 40000000;
  localparam int RESTART_MS = 100;
  localparam int RESTART_CYC = (CLK_HZ / 1000) * RESTART_MS;
  // Overcurrent filtering
  localparam int OC_CNT_W = 4;
  localparam logic [3:0] OC_EOC = 4'hf;
  localparam logic [3:0] CLEAN_PULSES = 4'hf;
  localparam int FOLDBACK_DIV = 4;
  localparam int FB_FOLD_MV = 500;
  localparam int HICCUP_SS_MULT = 3;
  // Voltage codes and step sizes
  localparam int VCODE_W = 8;
  localparam logic [7:0] STEP_FINE = 8'h01;
  localparam logic [7:0] STEP_COARSE = 8'h02;
  localparam int STEP_FINE_MV = 25;
  localparam int STEP_COARSE_MV = 50;
  // Hysteretic band
  localparam int HYST_BAND_PERMILLE = 29;
  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  // Operating modes
  typedef enum logic [1:0] {
    PMFC_ACTIVE = 2'b00,
    PMFC_LOWPWR = 2'b01,
    PMFC_PERF = 2'b10
  } pmfc_mode_t;
  // Supervisor states
  typedef enum logic [1:0] {
    PMFC_OFF = 2'b00,
    PMFC_RUN = 2'b01,
    PMFC_WAIT_COOL = 2'b10,
    PMFC_WAIT_RST = 2'b11
  } pmfc_sup_t;
endpackage : pmfc_pkg

//--- verilog/pmfc_sync.sv
module pmfc_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pmfc_sync_t;
  pmfc_sync_t state;
  pmfc_sync_t next_state;

  always_comb begin
    next_state = state;
    next_state.stage1 = i_async;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_sync = state.stage2;
endmodule : pmfc_sync

//--- verilog/pmfc_top.sv
// Operation
// [RL1] Performance pin reads as 0 while its unmask bit is clear.
// [RL2] Startup or restart never clears unmask bit or performance voltage codes.
// [RL3] Unmasked high performance pin at startup end enters performance at reset release.
// [RL4] Unprogrammed performance voltage falls back to active default.
// [RL5] Low-power entered first blocks later performance request while low-power pin high.
// [RL6] Performance state holds against low-power; host drops performance pin first.
// [RL7] First buck hysteretic mode only with enable and small headroom.
// [RL8] Thermal shutdown stops all channels, resets, interrupts if unmasked.
// [RL9] After cooling, wait 100 ms then restart automatically.
// [RL10] Thermal warning only interrupts when unmasked, no channel action.
// [RL11] Overcurrent with low feedback enters divide-by-four foldback.
// [RL12] Each overcurrent ends on-time and bumps four-bit counter.
// [RL13] Counter end-of-count with power-good low turns buck off, hiccup.
// [RL14] Global hiccup stops all, resets, interrupts if unmasked, restarts after 100 ms.
// [RL15] Per-channel hiccup affects one buck; reset only if sequenced.
// [RL16] Per-channel hiccup holds buck off three soft-starts, then soft-starts.
// [RL17] Reset releases after programmed delay once recovered power-good returns.
// [RL18] Fifteen clean turn-on pulses clear the overcurrent counter.
// [RL19] Counters advance on switching events, not time.
// [RL20] Overcurrent status per buck visible to host.
// [RL21] Forced PWM negative limit turns low side off, reported only.
// [RL22] LDO current limit reported only, no reset.
// [RL23] Power-good frozen during voltage scaling transitions.
// [RL24] Voltage changes step 25 mV, or 50 mV on first buck and LDOs.
// [RL25] Mode pins synchronised before arbitration.
module pmfc_top #(
  parameter int RESTART_CYCLES = pmfc_pkg::RESTART_CYC,
  parameter int SS_CYCLES = 4000,
  parameter int RST_DELAY_CYCLES = 400
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Host mode pins
  input wire logic i_perf_request_pin,
  input wire logic i_low_power_request_pin,
  input wire logic i_power_hold_pin,
  input wire logic i_start_button_n,
  // Configuration bits
  input wire logic i_perf_pin_unmask,
  input wire logic i_first_buck_hyst_enable,
  input wire logic [3:0] i_per_channel_hiccup_select,
  input wire logic [3:0] i_in_sequence,
  input wire logic i_mask_tsd,
  input wire logic i_mask_twarn,
  input wire logic i_mask_hiccup,
  // Voltage codes
  input wire logic [47:0] i_active_vcode,
  input wire logic [47:0] i_perf_vcode,
  input wire logic [5:0] i_perf_programmed,
  input wire logic [47:0] i_lowpwr_vcode,
  // Analog status
  input wire logic i_tsd_hot,
  input wire logic i_tsd_cool,
  input wire logic i_twarn,
  input wire logic i_headroom_low,
  input wire logic [5:0] i_power_good_raw,
  input wire logic [3:0] i_hs_turn_on,
  input wire logic [3:0] i_high_side_overcurrent,
  input wire logic [3:0] i_fb_below_fold,
  input wire logic [3:0] i_neg_limit,
  input wire logic [3:0] i_forced_pwm,
  input wire logic [1:0] i_ldo_limit,
  // Channel control
  output logic [5:0] o_channel_enable,
  output logic [5:0] o_soft_start,
  output logic [47:0] o_target_vcode,
  output logic [3:0] o_end_on_time,
  output logic [3:0] o_low_side_off,
  output logic [3:0] o_foldback,
  output logic o_hysteretic_light_load,
  // Host outputs
  output logic o_reset_out_n,
  output logic o_irq_out_n,
  output logic [1:0] o_mode,
  output logic [5:0] o_power_good,
  // Status readback
  output logic [3:0] o_oc_status,
  output logic [1:0] o_ldo_limit_status,
  output logic [3:0] o_neg_limit_status,
  output logic o_tsd_status,
  output logic o_twarn_status
);
  localparam int CNT_W = 32;
  if (RESTART_CYCLES < 1 || SS_CYCLES < 1 || RST_DELAY_CYCLES < 1) begin : g_bad_counts
    $error("pmfc_top: counts must be positive");
  end

  logic [2:0] pins_sync;
  logic perf_pin;
  logic lp_pin;
  logic hold_pin;
  logic [3:0] buck_hiccup;
  logic [3:0] hiccup_clear;
  logic global_hiccup;
  logic seq_hiccup;

  pmfc_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_async({i_perf_request_pin, i_low_power_request_pin, i_power_hold_pin}), // RL25
    .o_sync(pins_sync)
  );

  // Masked performance pin looks like a grounded pin
  assign perf_pin = pins_sync[2] && i_perf_pin_unmask; // RL1
  assign lp_pin = pins_sync[1];
  assign hold_pin = pins_sync[0];

  genvar gi;
  generate
    for (gi = 0; gi < pmfc_pkg::NUM_BUCK; gi++) begin : g_buck
      pmfc_buck_oc u_oc (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_hs_turn_on(i_hs_turn_on[gi]),
        .i_high_side_overcurrent(i_high_side_overcurrent[gi]),
        .i_fb_below_fold(i_fb_below_fold[gi]),
        .i_power_good(i_power_good_raw[gi]),
        .i_neg_limit(i_neg_limit[gi]),
        .i_forced_pwm(i_forced_pwm[gi]),
        .i_hiccup_clear(hiccup_clear[gi]),
        .o_end_on_time(o_end_on_time[gi]),
        .o_low_side_off(o_low_side_off[gi]),
        .o_hiccup(buck_hiccup[gi]),
        .o_foldback(o_foldback[gi]),
        .o_oc_status(o_oc_status[gi]),
        .o_oc_count()
      );
    end
  endgenerate

  typedef struct packed {
    pmfc_pkg::pmfc_sup_t sup;
    pmfc_pkg::pmfc_mode_t mode;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic [3:0][CNT_W-1:0] hic_cnt;
    logic [3:0] buck_off;
    logic [3:0] buck_ss;
    logic rst_n;
    logic tsd_flag;
    logic twarn_flag;
    logic hic_flag;
    logic [5:0] pg;
    logic [47:0] vcode;
    logic [3:0] neg_flag;
    logic [1:0] ldo_flag;
  } pmfc_top_t;
  pmfc_top_t state;
  pmfc_top_t next_state;

  logic [47:0] goal;
  logic [5:0] ramping;

  assign global_hiccup = |(buck_hiccup & ~i_per_channel_hiccup_select);
  assign seq_hiccup = |(buck_hiccup & i_per_channel_hiccup_select & i_in_sequence);

  // Goal voltages follow the selected mode; codes are host-held, never reset here
  always_comb begin
    goal = '0;
    for (int c = 0; c < pmfc_pkg::NUM_CH; c++) begin
      case (state.mode)
        pmfc_pkg::PMFC_PERF: begin
          goal[c*8 +: 8] = i_perf_programmed[c] ? i_perf_vcode[c*8 +: 8] // RL2
                                                : i_active_vcode[c*8 +: 8]; // RL4
        end
        pmfc_pkg::PMFC_LOWPWR: begin
          goal[c*8 +: 8] = i_lowpwr_vcode[c*8 +: 8];
        end
        default: begin
          goal[c*8 +: 8] = i_active_vcode[c*8 +: 8];
        end
      endcase
    end
  end

  always_comb begin
    logic [7:0] cur;
    logic [7:0] tgt;
    logic [7:0] step;
    logic [7:0] diff;
    cur = 8'h00;
    tgt = 8'h00;
    step = 8'h00;
    diff = 8'h00;
    next_state = state;
    ramping = '0;
    hiccup_clear = '0;

    // Voltage stepping toward goal
    for (int c = 0; c < pmfc_pkg::NUM_CH; c++) begin
      cur = state.vcode[c*8 +: 8];
      tgt = goal[c*8 +: 8];
      step = (c == 0 || c >= pmfc_pkg::NUM_BUCK) ? pmfc_pkg::STEP_COARSE
                                                  : pmfc_pkg::STEP_FINE; // RL24
      ramping[c] = (cur != tgt);
      if (cur < tgt) begin
        diff = tgt - cur;
        next_state.vcode[c*8 +: 8] = (diff < step) ? tgt : cur + step; // RL24
      end else if (cur > tgt) begin
        diff = cur - tgt;
        next_state.vcode[c*8 +: 8] = (diff < step) ? tgt : cur - step; // RL24
      end
      if (!ramping[c]) begin
        next_state.pg[c] = i_power_good_raw[c]; // RL23
      end
    end

    // Report-only events never touch reset
    next_state.neg_flag = state.neg_flag | (i_neg_limit & i_forced_pwm); // RL21
    next_state.ldo_flag = state.ldo_flag | i_ldo_limit; // RL22
    if (i_twarn) begin
      next_state.twarn_flag = 1'b1; // RL10
    end

    // Mode arbitration while running
    if (state.sup == pmfc_pkg::PMFC_RUN && hold_pin) begin
      case (state.mode)
        pmfc_pkg::PMFC_ACTIVE: begin
          if (perf_pin) begin
            next_state.mode = pmfc_pkg::PMFC_PERF; // RL3
          end else if (lp_pin) begin
            next_state.mode = pmfc_pkg::PMFC_LOWPWR; // RL5
          end
        end
        pmfc_pkg::PMFC_LOWPWR: begin
          if (!lp_pin) begin
            next_state.mode = perf_pin ? pmfc_pkg::PMFC_PERF : pmfc_pkg::PMFC_ACTIVE; // RL5
          end
        end
        pmfc_pkg::PMFC_PERF: begin
          if (!perf_pin) begin
            next_state.mode = lp_pin ? pmfc_pkg::PMFC_LOWPWR : pmfc_pkg::PMFC_ACTIVE; // RL6
          end
        end
        default: begin
          next_state.mode = pmfc_pkg::PMFC_ACTIVE;
        end
      endcase
    end

    // Per-channel hiccup timers
    for (int b = 0; b < pmfc_pkg::NUM_BUCK; b++) begin
      next_state.buck_ss[b] = 1'b0;
      if (buck_hiccup[b] && i_per_channel_hiccup_select[b] && !state.buck_off[b]) begin
        next_state.buck_off[b] = 1'b1; // RL15
        next_state.hic_cnt[b] = CNT_W'(pmfc_pkg::HICCUP_SS_MULT * SS_CYCLES); // RL16
        hiccup_clear[b] = 1'b1;
      end else if (state.buck_off[b]) begin
        if (state.hic_cnt[b] <= CNT_W'(1)) begin
          next_state.buck_off[b] = 1'b0;
          next_state.buck_ss[b] = 1'b1; // RL16
        end else begin
          next_state.hic_cnt[b] = state.hic_cnt[b] - CNT_W'(1);
        end
      end
    end

    // Reset release delay after power-good of sequenced rails
    if (state.sup == pmfc_pkg::PMFC_RUN && !state.rst_n) begin
      if (&(state.pg[3:0] | ~i_in_sequence) && !(|(state.buck_off & i_in_sequence))) begin
        if (state.rst_cnt >= CNT_W'(RST_DELAY_CYCLES - 1)) begin
          next_state.rst_n = 1'b1; // RL17
        end else begin
          next_state.rst_cnt = state.rst_cnt + CNT_W'(1);
        end
      end else begin
        next_state.rst_cnt = '0;
      end
    end
    if (seq_hiccup) begin
      next_state.rst_n = 1'b0; // RL15
      next_state.rst_cnt = '0;
      if (!i_mask_hiccup) begin
        next_state.hic_flag = 1'b1; // RL15
      end
    end

    // Supervisor
    case (state.sup)
      pmfc_pkg::PMFC_OFF: begin
        if (!i_start_button_n || hold_pin) begin
          next_state.sup = pmfc_pkg::PMFC_RUN;
          next_state.mode = pmfc_pkg::PMFC_ACTIVE;
          next_state.rst_cnt = '0;
        end
      end
      pmfc_pkg::PMFC_RUN: begin
        if (i_tsd_hot) begin
          next_state.sup = pmfc_pkg::PMFC_WAIT_COOL; // RL8
          next_state.rst_n = 1'b0;
          next_state.tsd_flag = state.tsd_flag | !i_mask_tsd; // RL8
        end else if (global_hiccup) begin
          next_state.sup = pmfc_pkg::PMFC_WAIT_RST; // RL14
          next_state.rst_n = 1'b0;
          next_state.wait_cnt = CNT_W'(RESTART_CYCLES);
          next_state.hic_flag = state.hic_flag | !i_mask_hiccup; // RL14
          hiccup_clear = buck_hiccup & ~i_per_channel_hiccup_select;
        end
      end
      pmfc_pkg::PMFC_WAIT_COOL: begin
        if (i_tsd_cool) begin
          next_state.sup = pmfc_pkg::PMFC_WAIT_RST; // RL9
          next_state.wait_cnt = CNT_W'(RESTART_CYCLES);
        end
      end
      pmfc_pkg::PMFC_WAIT_RST: begin
        if (state.wait_cnt <= CNT_W'(1)) begin
          next_state.sup = pmfc_pkg::PMFC_RUN; // RL9
          next_state.mode = pmfc_pkg::PMFC_ACTIVE;
          next_state.rst_cnt = '0;
          next_state.buck_off = '0;
        end else begin
          next_state.wait_cnt = state.wait_cnt - CNT_W'(1);
        end
      end
      default: begin
        next_state.sup = pmfc_pkg::PMFC_OFF;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Channels gated by supervisor and per-buck hiccup
  always_comb begin
    o_channel_enable = '0;
    if (state.sup == pmfc_pkg::PMFC_RUN) begin
      o_channel_enable = {2'b11, ~state.buck_off}; // RL8
    end
  end
  assign o_soft_start = {2'b00, state.buck_ss};
  assign o_target_vcode = state.vcode;
  // Headroom comparator is analog; digital side just gates it
  assign o_hysteretic_light_load = i_first_buck_hyst_enable && i_headroom_low; // RL7
  assign o_reset_out_n = state.rst_n;
  assign o_irq_out_n = !(state.tsd_flag || state.hic_flag ||
                         (state.twarn_flag && !i_mask_twarn)); // RL10
  assign o_mode = state.mode;
  assign o_power_good = state.pg;
  assign o_ldo_limit_status = state.ldo_flag;
  assign o_neg_limit_status = state.neg_flag;
  assign o_tsd_status = state.tsd_flag;
  assign o_twarn_status = state.twarn_flag;
endmodule : pmfc_top
